// ==== logic/hlc_pkg.sv ====
// Package: offsets, field positions, reset values and carriers
package hlc_pkg;
	localparam logic [7:0] OFF_ROM_BASE = 8'h34;
	localparam logic [7:0] OFF_FAIL_LO = 8'h38;
	localparam logic [7:0] OFF_FAIL_HI = 8'h3c;
	localparam logic [7:0] OFF_VENDOR = 8'h40;
	localparam logic [7:0] OFF_CTRL_SET = 8'h50;
	localparam logic [7:0] OFF_CTRL_CLR = 8'h54;
	localparam int ROM_BASE_LSB = 10;
	localparam int ROM_OFFS_BITS = 10;
	localparam logic [31:0] ROM_BASE_MASK = 32'hffff_fc00;
	localparam logic [47:0] ROM_WIN_LO = 48'hffff_f000_0400;
	localparam logic [47:0] ROM_WIN_HI = 48'hffff_f000_07ff;
	localparam int BIT_BIB_OK = 31;
	localparam int BIT_KEEP_ORDER = 30;
	localparam int BIT_LATE_ACK = 29;
	localparam int BIT_DRV_OWNS = 23;
	localparam int BIT_PHY_ON = 22;
	localparam int BIT_LPS = 19;
	localparam int BIT_POSTING = 18;
	localparam int BIT_LINK = 17;
	localparam int BIT_RESTART = 16;
	// Implemented control bits; 28:24, 21:20 and 15:0 read zero
	localparam logic [31:0] CTRL_MASK = 32'he0cf_0000;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] ROM_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] VENDOR_VALUE = 32'h0000_0000;
	localparam logic [31:0] FAIL_RESET = 32'h0000_0000;
	localparam int RESTART_CYCLES = 8;
	typedef struct packed {
		logic [47:0] offset;
		logic [15:0] requester;
	} hlc_fail_t;
	typedef struct packed {
		logic bibOk;
		logic keepOrder;
		logic lateAck;
		logic drvOwns;
		logic phyOn;
		logic link_power_state;
		logic posting;
		logic link;
		logic restart;
	} hlc_flags_t;
endpackage

// ==== logic/hlc_regs.sv ====
// Host link control registers: ROM map, failed post capture, control flags
// How it works
// RULE1: ROM window quadlet read address is base plus offset low ten bits.
// RULE2: Reserved bits of mapping and control registers always read zero.
// RULE3: Failed posted write stores destination offset low 32 bits.
// RULE4: Failed posted write stores offset upper 16 bits in high 15:0.
// RULE5: Failed posted write stores requester bus/node id in high 31:16.
// RULE6: Vendor identity register reads all zero.
// RULE7: Control flags have a set address and a clear address.
// RULE8: Image flag zero: block ROM reads get type error, no reset update.
// RULE9: Image flag one: block ROM reads served, automatic ROM update on.
// RULE10: Payload bytes swapped when keep order flag is zero.
// RULE11: Late ack flag allows ack_tardy on ROM, forces it elsewhere.
// RULE12: Feature ownership flag loads from EEPROM; software may only clear.
// RULE13: Software touches PHY enhancements only while it owns them.
// RULE14: Software sets feature enable only when owning and link inactive.
// RULE15: Link power state pin follows its flag directly.
// RULE16: Posted writes accepted only while posting flag is one.
// RULE17: Software should change posting flag only while link inactive.
// RULE18: Link inactive disconnects from bus; both resets clear it.
// RULE19: Local restart resets state and registers, stays set until done; the failure capture registers are not reset by it.
// RULE20: Ones set or clear flags, zeros ignored, both addresses read flags.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module hlc_regs #(
	parameter int RESTART_LEN = hlc_pkg::RESTART_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic eepromLoad,
	input wire logic eepromOwns,
	input wire logic romReq,
	input wire logic romBlock,
	input wire logic [47:0] romOffset,
	output logic [31:0] romHostAddr,
	output logic romAddrValid,
	output logic romTypeError,
	output logic romServe,
	input wire logic busReset,
	output logic romAutoUpdate,
	input wire logic ackReq,
	input wire logic ackIsRom,
	output logic ackTardy,
	input wire logic [31:0] payloadIn,
	output logic [31:0] payloadOut,
	input wire logic postReq,
	output logic postAccept,
	input wire logic postFail,
	input wire hlc_pkg::hlc_fail_t postFailInfo,
	output logic linkPowerState,
	output logic linkConnected,
	output logic phyFeaturesOn,
	output logic restartActive
);
	hlc_pkg::hlc_flags_t flags;
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	logic [31:0] romBase_r;
	logic [31:0] failLo_r;
	logic [31:0] failHi_r;
	logic restartBusy;
	logic restartDone;
	logic [31:0] rdata;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	wire logic access = psel && penable;
	// Writes land only on the edge that completes the transfer
	wire logic wr = access && pwrite && pready;
	wire logic hitBase = hit(paddr, hlc_pkg::OFF_ROM_BASE);
	wire logic hitLo = hit(paddr, hlc_pkg::OFF_FAIL_LO);
	wire logic hitHi = hit(paddr, hlc_pkg::OFF_FAIL_HI);
	wire logic hitVend = hit(paddr, hlc_pkg::OFF_VENDOR);
	wire logic hitSet = hit(paddr, hlc_pkg::OFF_CTRL_SET);
	wire logic hitClr = hit(paddr, hlc_pkg::OFF_CTRL_CLR);
	wire logic mapped = hitBase | hitLo | hitHi | hitVend | hitSet | hitClr;
	wire logic wrSet = wr && hitSet; // RULE7
	wire logic wrClr = wr && hitClr; // RULE7
	wire logic [31:0] setMask = wrSet ? (pwdata & hlc_pkg::CTRL_MASK) : 32'h0;
	wire logic [31:0] clrMask = wrClr ? (pwdata & hlc_pkg::CTRL_MASK) : 32'h0;
	// No set path for ownership; an EEPROM load wins over a clear
	wire logic ownsNxt = eepromLoad ? eepromOwns : // RULE12
		ctrl_r[hlc_pkg::BIT_DRV_OWNS] & ~clrMask[hlc_pkg::BIT_DRV_OWNS];

	assign flags.bibOk = ctrl_r[hlc_pkg::BIT_BIB_OK];
	assign flags.keepOrder = ctrl_r[hlc_pkg::BIT_KEEP_ORDER];
	assign flags.lateAck = ctrl_r[hlc_pkg::BIT_LATE_ACK];
	assign flags.drvOwns = ctrl_r[hlc_pkg::BIT_DRV_OWNS];
	assign flags.phyOn = ctrl_r[hlc_pkg::BIT_PHY_ON];
	assign flags.link_power_state = ctrl_r[hlc_pkg::BIT_LPS];
	assign flags.posting = ctrl_r[hlc_pkg::BIT_POSTING];
	assign flags.link = ctrl_r[hlc_pkg::BIT_LINK];
	assign flags.restart = ctrl_r[hlc_pkg::BIT_RESTART];

	wire logic startRestart = setMask[hlc_pkg::BIT_RESTART] && !restartBusy;

	hlc_restart_seq #(
		.CYCLES(RESTART_LEN)
	) u_restart (
		.clk(clk),
		.rst(rst),
		.start(startRestart),
		.busy(restartBusy),
		.done(restartDone)
	);

	// Set wins over clear on the same bit; ownership flag has no set path
	always_comb begin
		ctrl_nxt = (ctrl_r | setMask) & ~(clrMask & ~setMask); // RULE20
		ctrl_nxt[hlc_pkg::BIT_DRV_OWNS] = ownsNxt; // RULE12
		if (restartDone) begin
			// Restart lands on hardware reset values, ownership kept
			ctrl_nxt = hlc_pkg::CTRL_RESET; // RULE19
			ctrl_nxt[hlc_pkg::BIT_DRV_OWNS] = ownsNxt;
		end else if (restartBusy) begin
			ctrl_nxt[hlc_pkg::BIT_RESTART] = 1'b1; // RULE19
			ctrl_nxt[hlc_pkg::BIT_LINK] = 1'b0; // RULE18
		end
		ctrl_nxt = ctrl_nxt & hlc_pkg::CTRL_MASK; // RULE2
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= hlc_pkg::CTRL_RESET; // RULE18
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// Mapping base; reserved low bits never stored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			romBase_r <= hlc_pkg::ROM_BASE_RESET;
		end else if (restartDone) begin
			romBase_r <= hlc_pkg::ROM_BASE_RESET; // RULE19
		end else if (wr && hitBase) begin
			romBase_r <= pwdata & hlc_pkg::ROM_BASE_MASK; // RULE2
		end
	end

	// Failure capture; a failure with posting off cannot happen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			failLo_r <= hlc_pkg::FAIL_RESET;
		end else if (postFail) begin
			failLo_r <= postFailInfo.offset[31:0]; // RULE3
		end
	end

	// Requester id above the offset's upper 16 bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			failHi_r <= hlc_pkg::FAIL_RESET;
		end else if (postFail) begin
			failHi_r[15:0] <= postFailInfo.offset[47:32]; // RULE4
			failHi_r[31:16] <= postFailInfo.requester; // RULE5
		end
	end

	wire logic inWindow = (romOffset >= hlc_pkg::ROM_WIN_LO) &&
		(romOffset <= hlc_pkg::ROM_WIN_HI);
	wire logic [31:0] romSum = romBase_r +
		{22'h0, romOffset[hlc_pkg::ROM_OFFS_BITS-1:0]}; // RULE1
	wire logic linkUp = flags.link && !flags.restart;
	wire logic romQuad = romReq && inWindow && !romBlock && linkUp;
	wire logic romBlk = romReq && inWindow && romBlock && linkUp;

	assign rdata = hitBase ? romBase_r :
		hitLo ? failLo_r :
		hitHi ? failHi_r :
		hitVend ? hlc_pkg::VENDOR_VALUE : // RULE6
		(hitSet || hitClr) ? ctrl_r : // RULE20
		32'h0;

	// Answer one cycle into access phase, unmapped gets pslverr
	wire logic answerNxt = access && !pready;
	wire logic errNxt = answerNxt && !mapped;
	// Reads load data every access cycle; writes leave zero behind
	wire logic [31:0] prdataNxt = (psel && !pwrite) ? rdata : 32'h0;

	// Pulse, so a held request is never answered in two cycles running
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= answerNxt;
		end
	end

	// Error rides with the ready pulse only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= errNxt;
		end
	end

	// Read data stands in the cycle of the ready pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0;
		end else begin
			prdata <= prdataNxt;
		end
	end

	// Byte lanes reversed unless software asks to keep order
	logic [31:0] swapped;
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
			assign swapped[8*lane +: 8] = payloadIn[8*(3-lane) +: 8]; // RULE10
		end
	endgenerate
	wire logic [31:0] payloadNxt = flags.keepOrder ? payloadIn : swapped;

	// Decoded here, only registered in the blocks below
	wire logic typeErrNxt = romBlk && !flags.bibOk;
	wire logic serveNxt = romBlk && flags.bibOk;
	// No ROM image refresh on bus reset while the image flag is zero
	wire logic autoUpdNxt = busReset && flags.bibOk && linkUp;
	// Tardy on every packet, ROM included; ROM may but need not get it
	wire logic tardyNxt = ackReq && linkUp && flags.lateAck;
	wire logic postOkNxt = postReq && flags.posting && linkUp;
	// Enable meaningful only under driver ownership
	wire logic phyOnNxt = flags.phyOn && flags.drvOwns;

	// Address follows the base every cycle; the valid pulse qualifies it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			romHostAddr <= 32'h0;
		end else begin
			romHostAddr <= romSum; // RULE1
		end
	end

	// Quad reads only; block reads go to serve or type error
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			romAddrValid <= 1'b0;
		end else begin
			romAddrValid <= romQuad; // RULE1
		end
	end

	// Image not ready yet: refuse block reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			romTypeError <= 1'b0;
		end else begin
			romTypeError <= typeErrNxt; // RULE8
		end
	end

	// Image ready: hand block reads to the response unit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			romServe <= 1'b0;
		end else begin
			romServe <= serveNxt; // RULE9
		end
	end

	// Keeps mapping and header untouched while the image is invalid
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			romAutoUpdate <= 1'b0;
		end else begin
			romAutoUpdate <= autoUpdNxt; // RULE8 RULE9
		end
	end

	// Ack choice waits for the flag, never for the packet kind
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ackTardy <= 1'b0;
		end else begin
			ackTardy <= tardyNxt; // RULE11
		end
	end

	// One cycle of latency on the payload path
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			payloadOut <= 32'h0;
		end else begin
			payloadOut <= payloadNxt; // RULE10
		end
	end

	// Posting needs both the flag and a live link
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			postAccept <= 1'b0;
		end else begin
			postAccept <= postOkNxt; // RULE16 RULE18
		end
	end

	// Straight copy of the flag, not gated by link state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			linkPowerState <= 1'b0;
		end else begin
			linkPowerState <= flags.link_power_state; // RULE15
		end
	end

	// Down while restarting even if the link flag is still set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			linkConnected <= 1'b0;
		end else begin
			linkConnected <= linkUp; // RULE18
		end
	end

	// Hides a stale enable once ownership is cleared
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phyFeaturesOn <= 1'b0;
		end else begin
			phyFeaturesOn <= phyOnNxt; // RULE13 RULE14
		end
	end

	// Mirrors the self-clearing restart flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restartActive <= 1'b0;
		end else begin
			restartActive <= flags.restart; // RULE19
		end
	end

	// Packet kind not needed: tardy is given alike to ROM and others
	wire logic unusedAckRom = ackIsRom;
endmodule
`default_nettype wire

// ==== logic/hlc_restart_seq.sv ====
// Local restart sequencer: holds a pulse-started restart for a fixed time
`timescale 1ns/1ns
`default_nettype none
module hlc_restart_seq #(
	parameter int CYCLES = hlc_pkg::RESTART_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	output logic busy,
	output logic done
);
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic busy_nxt;
	wire logic lastCycle = busy && (count_r == 16'h0001);
	assign count_nxt = start && !busy ? CYCLES[15:0] :
		busy ? count_r - 16'h0001 : count_r;
	assign busy_nxt = (start && !busy) || (busy && !lastCycle);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_r <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			count_r <= count_nxt;
			busy <= busy_nxt;
			done <= lastCycle;
		end
	end
endmodule
`default_nettype wire

// ==== test/hlc_regs_properties.sv ====
// Checker: port assertions for the host link control registers
`timescale 1ns/1ns
`default_nettype none
module hlc_regs_properties #(
	parameter int RESTART_LEN = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic romReq,
	input wire logic romBlock,
	input wire logic [47:0] romOffset,
	input wire logic [31:0] romHostAddr,
	input wire logic romAddrValid,
	input wire logic romTypeError,
	input wire logic romServe,
	input wire logic ackReq,
	input wire logic ackTardy,
	input wire logic postReq,
	input wire logic postAccept,
	input wire logic linkConnected,
	input wire logic restartActive
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence apbRead(logic [7:0] a);
		pready && !pwrite && paddr == a;
	endsequence
	AST_ROM_ADDR: assert property (romAddrValid |->
		$past(romReq && !romBlock) && romHostAddr[9:0] == $past(romOffset[9:0]))
		else $error("rom address not base plus offset");
	AST_MAP_RSVD: assert property (apbRead(hlc_pkg::OFF_ROM_BASE) |->
		prdata[9:0] == 10'h0) else $error("map low bits not zero");
	AST_CTRL_RSVD: assert property (apbRead(hlc_pkg::OFF_CTRL_SET) |->
		(prdata & ~hlc_pkg::CTRL_MASK) == 32'h0)
		else $error("control reserved bits not zero");
	AST_VENDOR: assert property (apbRead(hlc_pkg::OFF_VENDOR) |->
		prdata == 32'h0) else $error("vendor word not zero");
	AST_TYPE_ERR: assert property (romTypeError |->
		$past(romReq && romBlock) && !romServe) else $error("bad type error");
	AST_SERVE: assert property (romServe |-> $past(romReq && romBlock))
		else $error("serve without block read");
	AST_TARDY: assert property (ackTardy |-> $past(ackReq))
		else $error("tardy without request");
	AST_POST: assert property (postAccept |-> $past(postReq))
		else $error("accept without post");
	AST_LINK_OFF: assert property (restartActive |-> !linkConnected)
		else $error("connected during restart");
	// Restart length fixed at the default count
	AST_RESTART: assert property ($rose(restartActive) |->
		restartActive[*8] ##[1:4] !restartActive) else $error("restart length");
endmodule
bind hlc_regs hlc_regs_properties #(.RESTART_LEN(RESTART_LEN))
	hlc_regs_properties_inst (.*);
`default_nettype wire

// ==== test/hlc_remote_node.sv ====
// Remote node model: ROM reads, acks, posts, failures, bus resets
`timescale 1ns/1ns
`default_nettype none
module hlc_remote_node (
	input wire logic clk,
	output logic romReq = 1'h0,
	output logic romBlock = 1'h0,
	output logic [47:0] romOffset = '1,
	output logic ackReq = 1'h0,
	output logic postReq = 1'h0,
	output logic postFail = 1'h0,
	output logic busReset = 1'h0,
	output hlc_pkg::hlc_fail_t postFailInfo = '1
);
	// Kinds: 0 quad, 1 block, 2 ack, 3 post, 4 fail, 5 bus reset
	task automatic send(input logic [2:0] k, input logic [63:0] v);
		romReq <= k < 3'h2;
		romBlock <= k == 3'h1;
		ackReq <= k == 3'h2;
		postReq <= k == 3'h3;
		postFail <= k == 3'h4;
		busReset <= k == 3'h5;
		romOffset <= v[63:16];
		postFailInfo <= v;
		@(posedge clk);
		{romReq, ackReq, postReq, postFail, busReset} <= 5'h0;
		// Idle lines flip so stale values never look valid
		romOffset <= ~v[63:16];
		postFailInfo <= ~v;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ==== test/test_host_link_control_registers.sv ====
// Testbench: register, ROM, post and restart behaviour
`timescale 1ns/1ns
`default_nettype none
module test_host_link_control_registers;
	logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic eepromLoad = 1'h0, eepromOwns = 1'h0, ackIsRom = 1'h0, err;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, payloadIn = 32'h0, prdata, rd;
	logic [31:0] romHostAddr, payloadOut;
	logic pready, pslverr, romReq, romBlock, romAddrValid, romTypeError;
	logic romServe, busReset, romAutoUpdate, ackReq, ackTardy, postReq;
	logic postAccept, postFail, linkPowerState, linkConnected;
	logic phyFeaturesOn, restartActive;
	logic [47:0] romOffset;
	hlc_pkg::hlc_fail_t postFailInfo;
	int miscompares = 0, totalChecks = 0;
	hlc_regs hlc_regs_inst (.*);
	hlc_remote_node hlc_remote_node_inst (.*);
	always #5 clk = ~clk;
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		totalChecks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk("read", rd, e);
	endtask
	initial begin
		#50000;
		miscompares++;
		endOfTest;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rchk(hlc_pkg::OFF_CTRL_SET, 32'h0);
		apb(1'h1, hlc_pkg::OFF_CTRL_SET, 32'h0080_0000);
		rchk(hlc_pkg::OFF_CTRL_CLR, 32'h0);
		apb(1'h1, hlc_pkg::OFF_ROM_BASE, 32'hffff_ffff);
		rchk(hlc_pkg::OFF_ROM_BASE, 32'hffff_fc00);
		apb(1'h1, hlc_pkg::OFF_VENDOR, 32'hffff_ffff);
		rchk(hlc_pkg::OFF_VENDOR, 32'h0);
		apb(1'h0, 8'h44, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		eepromOwns <= 1'h1;
		eepromLoad <= 1'h1;
		@(posedge clk);
		eepromLoad <= 1'h0;
		// Features and posting set while the link is still down
		apb(1'h1, hlc_pkg::OFF_CTRL_SET, 32'hffec_ffff);
		apb(1'h1, hlc_pkg::OFF_CTRL_SET, 32'h0002_0000);
		rchk(hlc_pkg::OFF_CTRL_CLR, 32'he0ce_0000);
		apb(1'h1, hlc_pkg::OFF_CTRL_CLR, 32'h4000_0000);
		rchk(hlc_pkg::OFF_CTRL_SET, 32'ha0ce_0000);
		chk("pins", {linkPowerState, phyFeaturesOn}, 32'h3);
		payloadIn <= 32'h1122_3344;
		repeat (2) @(posedge clk);
		chk("payload", payloadOut, 32'h4433_2211);
		hlc_remote_node_inst.send(3'h0, {48'hffff_f000_0404, 16'h0});
		chk("romaddr", {romAddrValid, romHostAddr[30:0]}, 32'hffff_fc04);
		hlc_remote_node_inst.send(3'h1, {48'hffff_f000_0400, 16'h0});
		chk("serve", {romServe, romTypeError}, 32'h2);
		hlc_remote_node_inst.send(3'h5, 64'h0);
		chk("update", {31'h0, romAutoUpdate}, 32'h1);
		hlc_remote_node_inst.send(3'h2, 64'h0);
		chk("tardy", {31'h0, ackTardy}, 32'h1);
		hlc_remote_node_inst.send(3'h3, 64'h0);
		chk("post", {31'h0, postAccept}, 32'h1);
		hlc_remote_node_inst.send(3'h4, 64'h1234_5678_9abc_def0);
		rchk(hlc_pkg::OFF_FAIL_LO, 32'h5678_9abc);
		rchk(hlc_pkg::OFF_FAIL_HI, 32'hdef0_1234);
		apb(1'h1, hlc_pkg::OFF_CTRL_CLR, 32'h8002_0000);
		apb(1'h1, hlc_pkg::OFF_CTRL_CLR, 32'h0004_0000);
		chk("link", {31'h0, linkConnected}, 32'h0);
		hlc_remote_node_inst.send(3'h1, {48'hffff_f000_0400, 16'h0});
		chk("offline", {romServe, romTypeError}, 32'h0);
		apb(1'h1, hlc_pkg::OFF_CTRL_SET, 32'h0002_0000);
		hlc_remote_node_inst.send(3'h3, 64'h0);
		chk("nopost", {31'h0, postAccept}, 32'h0);
		hlc_remote_node_inst.send(3'h1, {48'hffff_f000_0400, 16'h0});
		chk("typeerr", {romServe, romTypeError}, 32'h1);
		apb(1'h1, hlc_pkg::OFF_CTRL_SET, 32'h0001_0000);
		@(posedge clk);
		chk("restart", {30'h0, restartActive, linkConnected}, 32'h2);
		repeat (12) @(posedge clk);
		rchk(hlc_pkg::OFF_CTRL_SET, 32'h0080_0000);
		rchk(hlc_pkg::OFF_ROM_BASE, 32'h0);
		endOfTest;
	end
endmodule
`default_nettype wire
